/* File: inc/marker_stream_if.sv */
/*
  link between the scaler output port and the write controller.
  assumes the bench supplies no clock here: the controller makes it.
*/
`timescale 1ns/1ns
`include "marker_stream_map.svh"

interface marker_stream_if;
  logic                 output_burst_clock;
  logic                 output_drive_enable;
  logic [`WORD_W-1:0]   port_data;
  logic                 port_data_oe;
  logic                 buffer_half_full_request;
  logic [1:0]           pointer_advance_hint;
  logic                 pixel_qualifier;
  logic                 line_qualifier;
  logic                 compensated_line_reference;
  logic                 horizontal_window_gate;
  logic                 vertical_window_gate;
  logic                 field_parity;

  modport scaler (
    input  output_burst_clock, output_drive_enable,
    output port_data, port_data_oe, buffer_half_full_request,
    output pointer_advance_hint, pixel_qualifier, line_qualifier,
    output compensated_line_reference, horizontal_window_gate,
    output vertical_window_gate, field_parity
  );

  modport controller (
    output output_burst_clock, output_drive_enable,
    input  port_data, port_data_oe, buffer_half_full_request,
    input  pointer_advance_hint, pixel_qualifier, line_qualifier,
    input  compensated_line_reference, horizontal_window_gate,
    input  vertical_window_gate, field_parity
  );
endinterface

/* File: inc/marker_stream_map.svh */
/*
  constants of the scaler output port and its write controller.
  assumes inclusion by bare name from package and modules.
*/
`ifndef MARKER_STREAM_MAP_SVH
`define MARKER_STREAM_MAP_SVH

// output buffer
`define FIFO_DEPTH    5'h10
`define FIFO_AW       4
`define CNT_W         5
`define HALF_LEVEL    5'h08
`define CNT_ONE       5'h01
`define PTR_ONE       4'h1

// word layout
`define WORD_W        32
`define PIX_W         24
`define ALPHA_BIT     24
`define EOL_BIT       25
`define EOF_BIT       26
`define PAD_BYTE      8'h01
`define CLAMP_HI      8'hFE
`define EOL_CODE      8'h00
`define EOF_CODE      8'hFF

// timing
`define LREF_DELAY    2
`define BURST_LEN     4'h8
`define PHASE_HIGH    3'h4
`define PHASE_LAST    3'h7
`define SETTLE_CYCLES 4'hC
`define SEEN_DEPTH    4

// controller
`define ADDR_W        18
`define SYNC_W        28

`endif

/* File: inc/marker_stream_pkg.sv */
/*
  types shared by both ends of the marker stream port.
  assumes marker_stream_map.svh is on the include path.
*/
`include "marker_stream_map.svh"

package marker_stream_pkg;

  typedef logic [`WORD_W-1:0] word_t;

  // gray coded along idle, burst, settle
  typedef enum logic [1:0] {
    WC_IDLE   = 2'h0,
    WC_BURST  = 2'h1,
    WC_SETTLE = 2'h3
  } wctl_state_e;

endpackage

/* File: rtl/frame_write_controller.sv */
/*
  memory controller end: makes the burst clock by a divider,
  samples pixels, inserts line and field markers, steps address.
  assumes the memory side accepts words with valid and ready.
*/
`timescale 1ns/1ns
`include "marker_stream_map.svh"

module frame_write_controller (
  // system
  input  wire logic                clock,
  input  wire logic                reset,
  // configuration
  input  wire logic                mode_transparent,
  input  wire logic                enable,
  // memory write stream
  output logic                     mem_valid,
  input  wire logic                mem_ready,
  output logic [`PIX_W-1:0]        mem_data,
  output logic [`ADDR_W-1:0]       mem_addr,
  // link
  marker_stream_if.controller      link
);

  localparam int EW = `ADDR_W + `PIX_W;

  logic [`SYNC_W-1:0]  s1_ff, s2_ff;
  logic [`PIX_W-1:0]   s_data;
  logic                s_pxq, s_req;
  logic [1:0]          s_hint;
  marker_stream_pkg::wctl_state_e state_ff, nxt_state;
  logic [2:0]          phase_ff, nxt_phase;
  logic [3:0]          count_ff, nxt_count;
  logic                clk_ff, nxt_clk;
  logic                oe_ff;
  logic                eol_ff, nxt_eol, eof_ff, nxt_eof;
  logic                frame_ff, nxt_frame;
  logic [`ADDR_W-1:0]  addr_ff, nxt_addr;
  logic [EW-1:0]       e0_ff, e1_ff, nxt_e0, nxt_e1, new_e;
  logic                v0_ff, v1_ff, nxt_v0, nxt_v1;
  logic                running, blocked, advance, tick, push, pop;
  logic [`PIX_W-1:0]   push_data;

  always_ff @(posedge clock) begin
    if (reset) begin
      s1_ff <= '0;
      s2_ff <= '0;
    end else begin
      s1_ff <= {link.buffer_half_full_request,
                link.pointer_advance_hint, link.pixel_qualifier,
                link.port_data[`PIX_W-1:0]};
      s2_ff <= s1_ff;
    end
  end

  assign {s_req, s_hint, s_pxq, s_data} = s2_ff;

  assign running = enable & (mode_transparent |
                   (state_ff == marker_stream_pkg::WC_BURST));
  assign blocked = v1_ff | eol_ff | eof_ff;
  assign advance = running & ~((phase_ff == `PHASE_LAST) &
                   (blocked | (!mode_transparent &&
                    count_ff == `BURST_LEN)));
  assign tick    = advance & (phase_ff == `PHASE_LAST);

  always_comb begin
    nxt_state = state_ff;
    nxt_count = count_ff;
    nxt_phase = running ? (advance ? phase_ff + 3'h1 : phase_ff)
                        : `PHASE_LAST;
    case (state_ff)
      marker_stream_pkg::WC_IDLE: begin
        nxt_count = '0;
        if (enable && !mode_transparent && s_req && !blocked)
          nxt_state = marker_stream_pkg::WC_BURST;
      end
      marker_stream_pkg::WC_BURST: begin
        if (tick)
          nxt_count = count_ff + 4'h1;
        if (!advance && phase_ff == `PHASE_LAST &&
            count_ff == `BURST_LEN) begin
          nxt_state = marker_stream_pkg::WC_SETTLE;
          nxt_count = `SETTLE_CYCLES;
        end
      end
      marker_stream_pkg::WC_SETTLE: begin
        nxt_count = count_ff - 4'h1;
        if (count_ff == 4'h0)
          nxt_state = marker_stream_pkg::WC_IDLE;
      end
      default: nxt_state = marker_stream_pkg::WC_IDLE;
    endcase
    nxt_clk = running && (nxt_phase < `PHASE_HIGH);
  end

  // pixel then end of line then end of field
  always_comb begin
    nxt_eol   = eol_ff;
    nxt_eof   = eof_ff;
    nxt_frame = frame_ff;
    push      = 1'b0;
    push_data = s_data;
    if (tick && s_pxq) begin
      push      = 1'b1;
      nxt_eol   = s_hint[0];
      nxt_eof   = s_hint[1];
      nxt_frame = &s_hint;
    end else if (eol_ff && !v1_ff) begin
      push      = 1'b1;
      push_data = {3{`EOL_CODE}};
      nxt_eol   = 1'b0;
    end else if (eof_ff && !eol_ff && !v1_ff) begin
      push      = 1'b1;
      push_data = {3{`EOF_CODE}};
      nxt_eof   = 1'b0;
    end
    nxt_addr = push ? addr_ff + {{(`ADDR_W-1){1'b0}}, 1'b1} : addr_ff;
    if (push && eof_ff && !eol_ff && frame_ff) begin
      nxt_addr  = '0;
      nxt_frame = 1'b0;
    end
  end

  // two entry buffer toward memory
  assign pop   = v0_ff & mem_ready;
  assign new_e = {addr_ff, push_data};

  always_comb begin
    nxt_e0 = e0_ff;
    nxt_e1 = e1_ff;
    nxt_v0 = v0_ff;
    nxt_v1 = v1_ff;
    if (pop) begin
      if (v1_ff) begin
        nxt_e0 = e1_ff;
        nxt_v1 = push;
        nxt_e1 = push ? new_e : e1_ff;
      end else begin
        nxt_v0 = push;
        nxt_e0 = push ? new_e : e0_ff;
      end
    end else if (push) begin
      if (!v0_ff) begin
        nxt_v0 = 1'b1;
        nxt_e0 = new_e;
      end else begin
        nxt_v1 = 1'b1;
        nxt_e1 = new_e;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_ff <= marker_stream_pkg::WC_IDLE;
      phase_ff <= `PHASE_LAST;
      count_ff <= '0;
      clk_ff   <= 1'b0;
      oe_ff    <= 1'b0;
      eol_ff   <= 1'b0;
      eof_ff   <= 1'b0;
      frame_ff <= 1'b0;
      addr_ff  <= '0;
      e0_ff    <= '0;
      e1_ff    <= '0;
      v0_ff    <= 1'b0;
      v1_ff    <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      phase_ff <= nxt_phase;
      count_ff <= nxt_count;
      clk_ff   <= nxt_clk;
      oe_ff    <= enable;
      eol_ff   <= nxt_eol;
      eof_ff   <= nxt_eof;
      frame_ff <= nxt_frame;
      addr_ff  <= nxt_addr;
      e0_ff    <= nxt_e0;
      e1_ff    <= nxt_e1;
      v0_ff    <= nxt_v0;
      v1_ff    <= nxt_v1;
    end
  end

  assign link.output_burst_clock  = clk_ff;
  assign link.output_drive_enable = oe_ff;
  assign mem_valid = v0_ff;
  assign mem_data  = e0_ff[`PIX_W-1:0];
  assign mem_addr  = e0_ff[EW-1:`PIX_W];

endmodule

/* File: rtl/scaler_output_port.sv */
/*
  scaler end of the marker stream port: sixteen word output buffer,
  burst request, preloaded output word, transparent mode gates.
  assumes the burst clock arrives from the controller on the link
  and is sampled here; the pixel source shares this clock.
*/
`timescale 1ns/1ns
`include "marker_stream_map.svh"

module scaler_output_port (
  // system
  input  wire logic         clock,
  input  wire logic         reset,
  // configuration
  input  wire logic         mode_transparent,
  input  wire logic         rgb_format,
  // pixel source
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [23:0]  in_data,
  input  wire logic         in_alpha,
  input  wire logic         in_line_end,
  input  wire logic         in_field_end,
  // raster timing
  input  wire logic         in_line_ref,
  input  wire logic         in_h_window,
  input  wire logic         in_v_window,
  input  wire logic         in_field_odd,
  // link
  marker_stream_if.scaler   link
);

  localparam marker_stream_pkg::word_t PAD_WORD =
    {{(`WORD_W-`PIX_W){1'b0}}, `PAD_BYTE, `PAD_BYTE, `PAD_BYTE};

  // link input synchronisers
  logic                  clk_s1_ff, clk_s2_ff, clk_s3_ff;
  logic                  oe_s1_ff, oe_s2_ff;
  logic                  burst_edge;

  // buffer state
  marker_stream_pkg::word_t mem_ff  [`FIFO_DEPTH];
  marker_stream_pkg::word_t nxt_mem [`FIFO_DEPTH];
  logic [`FIFO_AW-1:0]   wr_ff, nxt_wr;
  logic [`FIFO_AW-1:0]   rd_ff, nxt_rd;
  logic [`CNT_W-1:0]     cnt_ff, nxt_cnt;
  logic [`CNT_W-1:0]     ends_ff, nxt_ends;
  logic                  ready_ff, nxt_ready;
  logic                  push, pop;
  logic                  push_end, pop_end;
  marker_stream_pkg::word_t in_word, head;

  // port outputs
  marker_stream_pkg::word_t data_ff, nxt_data;
  logic                  req_ff, nxt_req;
  logic [1:0]            hint_ff, nxt_hint;
  logic                  pxq_ff, nxt_pxq;
  logic                  lnq_ff, nxt_lnq;
  logic [`LREF_DELAY-1:0] lref_ff, nxt_lref;
  logic                  hgate_ff, vgate_ff, parity_ff;
  logic [`SEEN_DEPTH-1:0] seen_ff, nxt_seen;

  // burst clock edge detect
  always_ff @(posedge clock) begin
    if (reset) begin
      clk_s1_ff <= 1'b0;
      clk_s2_ff <= 1'b0;
      clk_s3_ff <= 1'b0;
      oe_s1_ff  <= 1'b0;
      oe_s2_ff  <= 1'b0;
    end else begin
      clk_s1_ff <= link.output_burst_clock;
      clk_s2_ff <= clk_s1_ff;
      clk_s3_ff <= clk_s2_ff;
      oe_s1_ff  <= link.output_drive_enable;
      oe_s2_ff  <= oe_s1_ff;
    end
  end

  assign burst_edge = clk_s2_ff & ~clk_s3_ff;

  // word build
  always_comb begin
    logic [7:0] b;
    b       = 8'h00;
    in_word = '0;
    for (int i = 0; i < 3; i++) begin
      b = in_data[8*i +: 8];
      if (b == `EOL_CODE)
        b = `PAD_BYTE;
      else if (b == `EOF_CODE)
        b = `CLAMP_HI;
      in_word[8*i +: 8] = b;
    end
    if (!rgb_format)
      in_word[23:16] = `PAD_BYTE;
    in_word[`ALPHA_BIT] = in_alpha;
    in_word[`EOL_BIT]   = in_line_end;
    in_word[`EOF_BIT]   = in_field_end;
  end

  assign head     = mem_ff[rd_ff];
  assign push     = in_valid & ready_ff;
  // pop only a word the controller saw as real: it samples the port
  // through its own synchroniser, so a late pad to pixel swap is unseen
  assign pop      = burst_edge & seen_ff[`SEEN_DEPTH-1] & (cnt_ff != '0);
  assign push_end = push & (in_line_end | in_field_end);
  assign pop_end  = pop & (head[`EOL_BIT] | head[`EOF_BIT]);

  for (genvar g = 0; g < `FIFO_DEPTH; g++) begin : g_entry
    assign nxt_mem[g] = (push && wr_ff == (`FIFO_AW)'(g)) ?
                        in_word : mem_ff[g];
  end

  // buffer pointers and counts
  always_comb begin
    nxt_wr   = push ? wr_ff + `PTR_ONE : wr_ff;
    nxt_rd   = pop  ? rd_ff + `PTR_ONE : rd_ff;
    nxt_cnt  = cnt_ff;
    nxt_ends = ends_ff;
    if (push && !pop)
      nxt_cnt = cnt_ff + `CNT_ONE;
    else if (pop && !push)
      nxt_cnt = cnt_ff - `CNT_ONE;
    if (push_end && !pop_end)
      nxt_ends = ends_ff + `CNT_ONE;
    else if (pop_end && !push_end)
      nxt_ends = ends_ff - `CNT_ONE;
    nxt_ready = (nxt_cnt != `FIFO_DEPTH);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wr_ff    <= '0;
      rd_ff    <= '0;
      cnt_ff   <= '0;
      ends_ff  <= '0;
      ready_ff <= 1'b0;
    end else begin
      wr_ff    <= nxt_wr;
      rd_ff    <= nxt_rd;
      cnt_ff   <= nxt_cnt;
      ends_ff  <= nxt_ends;
      ready_ff <= nxt_ready;
    end
  end

  // storage has no reset
  always_ff @(posedge clock) begin
    mem_ff <= nxt_mem;
  end

  // port output values
  always_comb begin
    nxt_data = (cnt_ff == '0) ? PAD_WORD : head;
    nxt_pxq  = (cnt_ff != '0);
    nxt_hint = (cnt_ff == '0) ? 2'b00 :
               {head[`EOF_BIT], head[`EOL_BIT]};
    // half full, or a line or field end waits
    nxt_req  = !mode_transparent &&
               (cnt_ff >= `HALF_LEVEL || ends_ff != '0);
    nxt_lnq  = push | (lnq_ff & ~(pop & head[`EOL_BIT]));
    nxt_lref = {lref_ff[`LREF_DELAY-2:0], in_line_ref};
    // history of the qualifier as the far end samples it
    nxt_seen = {seen_ff[`SEEN_DEPTH-2:0], pxq_ff};
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      data_ff   <= PAD_WORD;
      pxq_ff    <= 1'b0;
      hint_ff   <= 2'b00;
      req_ff    <= 1'b0;
      lnq_ff    <= 1'b0;
      lref_ff   <= '0;
      seen_ff   <= '0;
      hgate_ff  <= 1'b0;
      vgate_ff  <= 1'b0;
      parity_ff <= 1'b0;
    end else begin
      data_ff   <= nxt_data;
      pxq_ff    <= nxt_pxq;
      hint_ff   <= nxt_hint;
      req_ff    <= nxt_req;
      lnq_ff    <= nxt_lnq;
      lref_ff   <= nxt_lref;
      seen_ff   <= nxt_seen;
      hgate_ff  <= in_h_window;
      vgate_ff  <= in_v_window;
      parity_ff <= in_field_odd;
    end
  end

  assign in_ready                        = ready_ff;
  assign link.port_data                  = data_ff;
  assign link.port_data_oe               = oe_s2_ff;
  assign link.buffer_half_full_request   = req_ff;
  assign link.pointer_advance_hint       = hint_ff;
  assign link.pixel_qualifier            = pxq_ff;
  assign link.line_qualifier             = lnq_ff;
  assign link.compensated_line_reference = lref_ff[`LREF_DELAY-1];
  assign link.horizontal_window_gate     = hgate_ff;
  assign link.vertical_window_gate       = vgate_ff;
  assign link.field_parity               = parity_ff;

endmodule

/* File: verif/marker_stream_chk.sv */
/*
  concurrent checks on the link between scaler end and write controller.
  assumes the bench feeds it the interface signals and the system clock.
*/
`timescale 1ns/1ns
`include "marker_stream_map.svh"

module marker_stream_chk (
  // system
  input wire logic               clock,
  input wire logic               reset,
  // link
  input wire logic               output_burst_clock,
  input wire logic               output_drive_enable,
  input wire logic [`WORD_W-1:0] port_data,
  input wire logic               port_data_oe,
  input wire logic               buffer_half_full_request,
  input wire logic [1:0]         pointer_advance_hint,
  input wire logic               pixel_qualifier,
  input wire logic               line_qualifier,
  input wire logic               compensated_line_reference,
  input wire logic               horizontal_window_gate,
  input wire logic               vertical_window_gate,
  input wire logic               field_parity
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  chk_high_phase_len: assert property (
    $rose(output_burst_clock) |-> output_burst_clock [*4] ##1
      !output_burst_clock) else $error("burst clock high phase wrong");
  chk_low_phase_len: assert property (
    $fell(output_burst_clock) |-> !output_burst_clock [*4])
    else $error("burst clock low phase too short");
  chk_pad_code_value: assert property (
    !pixel_qualifier |-> port_data == {8'h00, {3{`PAD_BYTE}}})
    else $error("pad word not coded 01");
  chk_no_sync_code: assert property (
    pixel_qualifier |-> port_data[23:16] != 8'h00 &&
      port_data[23:16] != 8'hFF && port_data[15:8] != 8'h00 &&
      port_data[15:8] != 8'hFF && port_data[7:0] != 8'h00 &&
      port_data[7:0] != 8'hFF) else $error("sync code in pixel");
  chk_hint_flag_match: assert property (
    pointer_advance_hint == port_data[26:25])
    else $error("pointer hint differs from word flags");
  chk_upper_bits_zero: assert property (
    port_data[31:27] == 5'h00) else $error("unused word bits set");
  chk_no_empty_request: assert property (
    (!pixel_qualifier) [*2] |-> !buffer_half_full_request)
    else $error("request with nothing queued");
  // the controller sees the port two cycles late
  chk_hold_sampled_word: assert property (
    $rose(output_burst_clock) && $past(pixel_qualifier, 2) |=>
      $stable(port_data) [*2])
    else $error("word changed while being sampled");
  chk_word_advance: assert property (
    $rose(output_burst_clock) && $past(pixel_qualifier, 2) |-> ##[3:7]
      $changed(port_data)) else $error("word not advanced");
  chk_line_qual_set: assert property (
    $rose(pixel_qualifier) |-> line_qualifier)
    else $error("pixel qualified outside a valid line");
  chk_oe_follow: assert property (
    output_drive_enable |-> ##2 port_data_oe)
    else $error("drive enable not followed");

  cover property ($rose(buffer_half_full_request));
  cover property (pixel_qualifier && pointer_advance_hint == 2'h3);
  cover property ($rose(output_burst_clock) && !pixel_qualifier);
endmodule

/* File: verif/scaler_output_marker_stream_port_tb.sv */
/*
  bench joining scaler end and write controller, checked against a model.
  assumes the design package, header and interface are compiled first.
*/
`timescale 1ns/1ns
`include "marker_stream_map.svh"

module scaler_output_marker_stream_port_tb;
  logic               clock;
  logic               reset;
  logic               mode_transparent;
  logic               rgb_format;
  logic               enable;
  logic               in_valid;
  logic               in_ready;
  logic [23:0]        in_data;
  logic               in_alpha;
  logic               in_line_end;
  logic               in_field_end;
  logic               in_line_ref;
  logic               in_h_window;
  logic               in_v_window;
  logic               in_field_odd;
  logic               mem_valid;
  logic               mem_ready;
  logic [`PIX_W-1:0]  mem_data;
  logic [`ADDR_W-1:0] mem_addr;
  logic [15:0]        rnd;
  logic [15:0]        rbits;
  logic               stall_en;
  logic [24:0]        exp_q[$];
  logic [`ADDR_W-1:0] exp_addr;
  logic [2:0]         raster_d1;
  logic [1:0]         lref_pipe;
  int                 n_errors;
  int                 check_count;
  int                 live;
  int                 len;

  marker_stream_if link ();

  scaler_output_port scaler_output_port_inst (
    .clock(clock), .reset(reset), .mode_transparent(mode_transparent),
    .rgb_format(rgb_format), .in_valid(in_valid), .in_ready(in_ready),
    .in_data(in_data), .in_alpha(in_alpha), .in_line_end(in_line_end),
    .in_field_end(in_field_end), .in_line_ref(in_line_ref),
    .in_h_window(in_h_window), .in_v_window(in_v_window),
    .in_field_odd(in_field_odd), .link(link)
  );

  frame_write_controller frame_write_controller_inst (
    .clock(clock), .reset(reset), .mode_transparent(mode_transparent),
    .enable(enable), .mem_valid(mem_valid), .mem_ready(mem_ready),
    .mem_data(mem_data), .mem_addr(mem_addr), .link(link)
  );

  marker_stream_chk marker_stream_chk_inst (
    .clock(clock), .reset(reset),
    .output_burst_clock(link.output_burst_clock),
    .output_drive_enable(link.output_drive_enable),
    .port_data(link.port_data), .port_data_oe(link.port_data_oe),
    .buffer_half_full_request(link.buffer_half_full_request),
    .pointer_advance_hint(link.pointer_advance_hint),
    .pixel_qualifier(link.pixel_qualifier),
    .line_qualifier(link.line_qualifier),
    .compensated_line_reference(link.compensated_line_reference),
    .horizontal_window_gate(link.horizontal_window_gate),
    .vertical_window_gate(link.vertical_window_gate),
    .field_parity(link.field_parity)
  );

  function automatic logic [15:0] next_rnd();
    rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
    return rnd;
  endfunction

  function automatic logic [7:0] clamp(input logic [7:0] b);
    return (b == 8'h00) ? `PAD_BYTE : ((b == 8'hFF) ? `CLAMP_HI : b);
  endfunction

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    check_word({31'h0, got}, {31'h0, exp});
  endtask

  task automatic print_verdict();
    $display("errors=%0d checks=%0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // expected stream: clamped pixel, then end markers
  task automatic model_push(input logic [23:0] d, input logic le, fe);
    logic [7:0] top;
    top = rgb_format ? clamp(d[23:16]) : `PAD_BYTE;
    exp_q.push_back({1'b0, top, clamp(d[15:8]), clamp(d[7:0])});
    if (le)
      exp_q.push_back({1'b0, `EOL_CODE, `EOL_CODE, `EOL_CODE});
    if (fe)
      exp_q.push_back({le, `EOF_CODE, `EOF_CODE, `EOF_CODE});
  endtask

  task automatic push_pixel(input logic le, input logic fe);
    logic [15:0] r;
    logic [23:0] d;
    int          n;
    r = next_rnd();
    d = {r[15:8], r[7:0], r[11:4]};
    if (r[13:12] == 2'h0)
      d[7:0] = 8'h00;
    if (r[13:12] == 2'h1)
      d[15:8] = 8'hFF;
    in_valid = 1'b1;
    in_data = d;
    in_alpha = r[14];
    in_line_end = le;
    in_field_end = fe;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (in_ready !== 1'b1 && n < 4000);
    check_flag(n < 4000, 1'b1);
    model_push(d, le, fe);
    #2;
  endtask

  task automatic idle(input int n);
    in_valid = 1'b0;
    repeat (n) @(posedge clock);
    #2;
  endtask

  task automatic drain();
    int n;
    in_valid = 1'b0;
    n = 0;
    while (exp_q.size() != 0 && n < 6000) begin
      @(posedge clock);
      n++;
    end
    check_flag(exp_q.size() == 0, 1'b1);
    #2;
  endtask

  task automatic do_reset(input logic m);
    reset = 1'b1;
    in_valid = 1'b0;
    mode_transparent = m;
    repeat (3) @(posedge clock);
    #2;
    exp_q.delete();
    exp_addr = '0;
    reset = 1'b0;
  endtask

  // memory side and raster timing, sampled before the edge updates
  always @(posedge clock) begin
    if (!reset && mem_valid === 1'b1 && mem_ready === 1'b1) begin
      check_flag(exp_q.size() != 0, 1'b1);
      if (exp_q.size() != 0) begin
        check_word({8'h0, mem_data}, {8'h0, exp_q[0][23:0]});
        check_word({14'h0, mem_addr}, {14'h0, exp_addr});
        exp_addr = exp_q[0][24] ? '0 : exp_addr + 1'b1;
        void'(exp_q.pop_front());
      end
    end
    if (live > 3) begin
      check_flag(link.compensated_line_reference, lref_pipe[1]);
      check_word({29'h0, link.horizontal_window_gate,
        link.vertical_window_gate, link.field_parity},
        {29'h0, raster_d1});
    end
    live = reset ? 0 : live + 1;
    lref_pipe = {lref_pipe[0], in_line_ref};
    raster_d1 = {in_h_window, in_v_window, in_field_odd};
    #2;
    rbits = next_rnd();
    mem_ready = stall_en ? (rbits[0] | rbits[1]) : 1'b1;
    in_line_ref = rbits[2];
    in_h_window = rbits[3];
    in_v_window = rbits[4];
    in_field_odd = rbits[5];
  end

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  initial begin
    #800000;
    n_errors++;
    print_verdict();
  end

  initial begin
    rnd = 16'hF954;
    reset = 1'b1;
    {mode_transparent, rgb_format, enable, in_valid, in_alpha} = '0;
    {in_line_end, in_field_end, in_line_ref, in_h_window} = '0;
    {in_v_window, in_field_odd, stall_en} = '0;
    mem_ready = 1'b1;
    in_data = '0;
    n_errors = 0;
    check_count = 0;
    live = 0;
    lref_pipe = '0;
    raster_d1 = '0;
    rgb_format = 1'b1;
    do_reset(1'b0);
    // fill with no bursts: request at eight, refusal at sixteen
    for (int i = 1; i <= 16; i++) begin
      push_pixel(1'b0, 1'b0);
      if (i == 7 || i == 8) begin
        idle(3);
        check_flag(link.buffer_half_full_request, i == 8);
      end
    end
    idle(3);
    check_flag(in_ready, 1'b0);
    enable = 1'b1;
    stall_en = 1'b1;
    drain();
    // lines, a field end alone, then a frame end, both formats and modes
    for (int m = 0; m < 2; m++) begin
      do_reset(m[0]);
      for (int f = 0; f < 2; f++) begin
        rgb_format = f[0];
        for (int ln = 0; ln < 4; ln++) begin
          len = 1 + int'(next_rnd() % 16'd12);
          for (int i = 0; i < len; i++)
            push_pixel(i == len - 1 && ln != 2, i == len - 1 && ln >= 2);
        end
        drain();
      end
    end
    idle(20);
    print_verdict();
  end
endmodule
